//--- hdl/pms_pkg.sv
// Shared constants for the loop status and miscellaneous register bank
package pms_pkg;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int DAC_W = 10;
	localparam int SEL_W = 5;
	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_FIXED_VALUE_B = 13'h0172;
	localparam logic [ADDR_W-1:0] OFS_LOOP_TWO_POWER = 13'h0173;
	localparam logic [ADDR_W-1:0] OFS_OSC_TUNING_A = 13'h017C;
	localparam logic [ADDR_W-1:0] OFS_OSC_TUNING_B = 13'h017D;
	localparam logic [ADDR_W-1:0] OFS_LOOP_ONE_LOCK = 13'h0182;
	localparam logic [ADDR_W-1:0] OFS_LOOP_TWO_LOCK = 13'h0183;
	localparam logic [ADDR_W-1:0] OFS_INPUT_SEL_LOS = 13'h0184;
	localparam logic [ADDR_W-1:0] OFS_DAC_LOW = 13'h0185;
	localparam logic [ADDR_W-1:0] OFS_HOLDOVER = 13'h0188;
	// Field positions
	localparam int BIT_PRESCALER_OFF = 6;
	localparam int BIT_LOOP_OFF = 5;
	localparam int BIT_LOST_FLAG = 2;
	localparam int BIT_LOCK_LIVE = 1;
	localparam int BIT_LOST_CLEAR = 0;
	localparam int BIT_SEL_C = 5;
	localparam int BIT_SEL_B = 4;
	localparam int BIT_SEL_A = 3;
	localparam int BIT_LOS_B = 1;
	localparam int BIT_LOS_A = 0;
	localparam int BIT_DAC_HIGH = 6;
	localparam int BIT_HOLDOVER = 4;
	// Writable bits of the power register; the rest are reserved
	localparam logic [DATA_W-1:0] MASK_LOOP_TWO_POWER = 8'h60;
	// Reset values
	localparam logic [DATA_W-1:0] RST_FIXED_VALUE_B = 8'h00;
	localparam logic [DATA_W-1:0] RST_LOOP_TWO_POWER = 8'h00;
	localparam logic [DATA_W-1:0] RST_OSC_TUNING = 8'h00;
	localparam logic [DAC_W-1:0] RST_DAC_VALUE = 10'h200;
	// Status pin selector code that routes loop two lock to a pin
	localparam logic [SEL_W-1:0] SEL_LOOP_TWO_LOCK = 5'h02;
	// Reference select codes
	localparam logic [1:0] REF_A = 2'h0;
	localparam logic [1:0] REF_B = 2'h1;
	localparam logic [1:0] REF_C = 2'h2;
	// Default lock counts of the two lock detectors
	localparam int LOCK_COUNT_DEFAULT = 16;
	localparam int LOCK_CNT_W = 16;
endpackage

//--- hdl/pms_lock_monitor.sv
// Digital lock detector with sticky lock-lost flag for one loop
`timescale 1ns/10ps
module pms_lock_monitor #(
	parameter int LOCK_COUNT = pms_pkg::LOCK_COUNT_DEFAULT
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic reset_in,
	// Phase detector observation
	input wire logic pd_event_in,
	input wire logic in_window_in,
	input wire logic force_unlock_in,
	// Flag control and status
	input wire logic lost_clear_in,
	output logic digital_lock_detect_out,
	output logic lost_flag_out
);
	import pms_pkg::*;

	initial begin
		if (LOCK_COUNT < 1 || LOCK_COUNT >= (1 << LOCK_CNT_W)) begin
			$error("LOCK_COUNT out of range");
		end
	end

	localparam logic [LOCK_CNT_W-1:0] LOCK_TARGET = LOCK_CNT_W'(LOCK_COUNT);

	logic [LOCK_CNT_W-1:0] lock_count;
	logic [LOCK_CNT_W-1:0] next_lock_count;
	logic lock_prev;

	always_comb begin
		next_lock_count = lock_count;
		if (force_unlock_in || (pd_event_in && !in_window_in)) begin
			next_lock_count = '0;
		end else if (pd_event_in && lock_count != LOCK_TARGET) begin
			next_lock_count = lock_count + 1'b1;
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			lock_count <= '0;
			digital_lock_detect_out <= 1'b0;
		end else begin
			lock_count <= next_lock_count;
			digital_lock_detect_out <= (next_lock_count == LOCK_TARGET);
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			lock_prev <= 1'b0;
		end else begin
			lock_prev <= digital_lock_detect_out;
		end
	end

	// A held clear outranks a falling edge; with the detector already low no
	// edge follows the release, so the flag stays clear
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			lost_flag_out <= 1'b0;
		end else if (lost_clear_in) begin
			lost_flag_out <= 1'b0;
		end else if (lock_prev && !digital_lock_detect_out) begin
			lost_flag_out <= 1'b1;
		end
	end

	sequence falling_lock_s;
		lock_prev && !digital_lock_detect_out;
	endsequence

	AST_FLAG_SET_ON_FALL: assert property (@(posedge clock_in) disable iff (reset_in)
		falling_lock_s ##0 !lost_clear_in |=> lost_flag_out)
		else $error("lost flag not set after falling lock");

	AST_FLAG_HELD_CLEAR: assert property (@(posedge clock_in) disable iff (reset_in)
		lost_clear_in |=> !lost_flag_out)
		else $error("lost flag set while clear held");

	AST_NO_SET_WITHOUT_FALL: assert property (@(posedge clock_in) disable iff (reset_in)
		!lost_flag_out && !(lock_prev && !digital_lock_detect_out) |=> !lost_flag_out)
		else $error("lost flag set without a falling edge");

	AST_COUNT_RESET: assert property (@(posedge clock_in) disable iff (reset_in)
		pd_event_in && !in_window_in |=> lock_count == '0 && !digital_lock_detect_out)
		else $error("lock counter not reset outside window");

	AST_LOCK_AFTER_COUNT: assert property (@(posedge clock_in) disable iff (reset_in)
		$rose(digital_lock_detect_out) |-> lock_count == LOCK_TARGET)
		else $error("lock declared before count reached");
endmodule // pms_lock_monitor

//--- hdl/pms_status_bank.sv
// Loop status and miscellaneous control register bank
// Behaviour
// - Power register bit 6 set powers down the loop-two prescaler.
// - Power register bit 5 set powers down the whole second loop.
// - Loop-one lock-lost flag sets on each falling edge of its lock detect while its clear bit is 0.
// - A flag cleared while lock detect is low stays clear until a later fall.
// - Loop-one lock status bit 1 shows the live loop-one lock level.
// - Loop-one clear bit holds the flag clear; host writes 1 then 0.
// - Loop-two lock-lost flag sets on each falling edge of its lock detect while its clear bit is 0.
// - Loop-two clear bit holds the flag clear; host writes 1 then 0.
// - Loop-two live bit valid only when a status pin selector equals 2.
// - Selection bits 5,4,3 show which reference feeds loop one.
// - Bits 1,0 show loss of signal on reference inputs b and a.
// - DAC readback upper two bits in 0x184[7:6], lower eight in 0x185.
// - DAC readback is 512 after reset, changing only after loop one locks.
// - Holdover register bit 4 reads 1 while in holdover.
// - Lock counters return to zero on an edge outside the window.
`timescale 1ns/10ps
module pms_status_bank #(
	parameter int LOOP_ONE_LOCK_COUNT = pms_pkg::LOCK_COUNT_DEFAULT,
	parameter int LOOP_TWO_LOCK_COUNT = pms_pkg::LOCK_COUNT_DEFAULT
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic reset_in,
	// Register port from the serial interface
	input wire logic [pms_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic [pms_pkg::DATA_W-1:0] reg_wdata_in,
	output logic [pms_pkg::DATA_W-1:0] reg_rdata_out,
	output logic reg_rvalid_out,
	// Loop one phase detector observation
	input wire logic loop_one_pd_event_in,
	input wire logic loop_one_in_window_in,
	// Loop two phase detector observation
	input wire logic loop_two_pd_event_in,
	input wire logic loop_two_in_window_in,
	// Reference selection and signal loss
	input wire logic ref_select_valid_in,
	input wire logic [1:0] ref_select_in,
	input wire logic ref_input_a_signal_loss_in,
	input wire logic ref_input_b_signal_loss_in,
	// Holdover DAC and state
	input wire logic dac_update_in,
	input wire logic [pms_pkg::DAC_W-1:0] dac_value_in,
	input wire logic holdover_active_in,
	// Status pin selectors
	input wire logic [pms_pkg::SEL_W-1:0] status_pin_a_selector_in,
	input wire logic [pms_pkg::SEL_W-1:0] status_pin_b_selector_in,
	// Control outputs
	output logic loop_two_prescaler_off_out,
	output logic loop_two_off_out,
	output logic [pms_pkg::DATA_W-1:0] fixed_value_b_out,
	output logic [pms_pkg::DATA_W-1:0] osc_tuning_a_out,
	output logic [pms_pkg::DATA_W-1:0] osc_tuning_b_out,
	output logic osc_tuning_loaded_out,
	// Lock status outputs
	output logic loop_one_lock_live_out,
	output logic loop_two_lock_live_out,
	output logic loop_two_lock_valid_out
);
	import pms_pkg::*;

	// Writable storage
	logic [DATA_W-1:0] fixed_value_b;
	logic [DATA_W-1:0] loop_two_power;
	logic [DATA_W-1:0] osc_tuning_a;
	logic [DATA_W-1:0] osc_tuning_b;
	logic loop_one_lock_lost_clear;
	logic loop_two_lock_lost_clear;
	logic tuning_a_written;
	logic tuning_b_written;

	// Status state
	logic loop_one_lock_live;
	logic loop_two_lock_live;
	logic loop_one_lock_lost_flag;
	logic loop_two_lock_lost_flag;
	logic [2:0] ref_selected;
	logic [1:0] ref_signal_loss;
	logic [DAC_W-1:0] holdover_dac_readback;
	logic loop_one_locked_once;
	logic holdover_active;

	logic [DATA_W-1:0] next_rdata;
	logic wr_power;

	assign wr_power = reg_write_in && reg_addr_in == OFS_LOOP_TWO_POWER;

	// Control registers; reserved bits of the power register never store
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			fixed_value_b <= RST_FIXED_VALUE_B;
			loop_two_power <= RST_LOOP_TWO_POWER;
		end else if (reg_write_in) begin
			if (reg_addr_in == OFS_FIXED_VALUE_B) begin
				fixed_value_b <= reg_wdata_in;
			end
			if (wr_power) begin
				loop_two_power <= reg_wdata_in & MASK_LOOP_TWO_POWER;
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			osc_tuning_a <= RST_OSC_TUNING;
			osc_tuning_b <= RST_OSC_TUNING;
			tuning_a_written <= 1'b0;
			tuning_b_written <= 1'b0;
		end else if (reg_write_in) begin
			if (reg_addr_in == OFS_OSC_TUNING_A) begin
				osc_tuning_a <= reg_wdata_in;
				tuning_a_written <= 1'b1;
			end
			if (reg_addr_in == OFS_OSC_TUNING_B) begin
				osc_tuning_b <= reg_wdata_in;
				tuning_b_written <= 1'b1;
			end
		end
	end

	// Only the clear bits of the lock status registers are writable
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			loop_one_lock_lost_clear <= 1'b0;
			loop_two_lock_lost_clear <= 1'b0;
		end else if (reg_write_in) begin
			if (reg_addr_in == OFS_LOOP_ONE_LOCK) begin
				loop_one_lock_lost_clear <= reg_wdata_in[BIT_LOST_CLEAR];
			end
			if (reg_addr_in == OFS_LOOP_TWO_LOCK) begin
				loop_two_lock_lost_clear <= reg_wdata_in[BIT_LOST_CLEAR];
			end
		end
	end

	assign loop_two_prescaler_off_out = loop_two_power[BIT_PRESCALER_OFF];
	assign loop_two_off_out = loop_two_power[BIT_LOOP_OFF];
	assign fixed_value_b_out = fixed_value_b;
	assign osc_tuning_a_out = osc_tuning_a;
	assign osc_tuning_b_out = osc_tuning_b;
	// Lets the calibration sequencer see both tuning words are in place
	assign osc_tuning_loaded_out = tuning_a_written && tuning_b_written;

	// Lock detectors; a powered-down second loop loses lock on the clock edge after its power bit sets
	pms_lock_monitor #(
		.LOCK_COUNT(LOOP_ONE_LOCK_COUNT)
	) u_loop_one (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.pd_event_in(loop_one_pd_event_in),
		.in_window_in(loop_one_in_window_in),
		.force_unlock_in(1'b0),
		.lost_clear_in(loop_one_lock_lost_clear),
		.digital_lock_detect_out(loop_one_lock_live),
		.lost_flag_out(loop_one_lock_lost_flag)
	);

	pms_lock_monitor #(
		.LOCK_COUNT(LOOP_TWO_LOCK_COUNT)
	) u_loop_two (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.pd_event_in(loop_two_pd_event_in),
		.in_window_in(loop_two_in_window_in),
		.force_unlock_in(loop_two_power[BIT_LOOP_OFF]),
		.lost_clear_in(loop_two_lock_lost_clear),
		.digital_lock_detect_out(loop_two_lock_live),
		.lost_flag_out(loop_two_lock_lost_flag)
	);

	assign loop_one_lock_live_out = loop_one_lock_live;
	assign loop_two_lock_live_out = loop_two_lock_live;
	// Loop two live level always reaches readback; the valid output is set when a pin selects it
	assign loop_two_lock_valid_out = status_pin_a_selector_in == SEL_LOOP_TWO_LOCK
		|| status_pin_b_selector_in == SEL_LOOP_TWO_LOCK;

	// Reference selection as one-hot; code 3 or no valid selection shows none
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			ref_selected <= 3'h0;
		end else if (!ref_select_valid_in) begin
			ref_selected <= 3'h0;
		end else begin
			case (ref_select_in)
				REF_A: ref_selected <= 3'h1;
				REF_B: ref_selected <= 3'h2;
				REF_C: ref_selected <= 3'h4;
				default: ref_selected <= 3'h0;
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			ref_signal_loss <= 2'h0;
			holdover_active <= 1'b0;
		end else begin
			ref_signal_loss <= {ref_input_b_signal_loss_in, ref_input_a_signal_loss_in};
			holdover_active <= holdover_active_in;
		end
	end

	// DAC readback holds its reset value until loop one has locked once
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			loop_one_locked_once <= 1'b0;
		end else if (loop_one_lock_live) begin
			loop_one_locked_once <= 1'b1;
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			holdover_dac_readback <= RST_DAC_VALUE;
		end else if (dac_update_in && loop_one_locked_once) begin
			holdover_dac_readback <= dac_value_in;
		end
	end

	// Read mux; unmapped offsets and reserved bits return zero
	always_comb begin
		next_rdata = '0;
		case (reg_addr_in)
			OFS_FIXED_VALUE_B: next_rdata = fixed_value_b;
			OFS_LOOP_TWO_POWER: next_rdata = loop_two_power;
			OFS_OSC_TUNING_A: next_rdata = osc_tuning_a;
			OFS_OSC_TUNING_B: next_rdata = osc_tuning_b;
			OFS_LOOP_ONE_LOCK: begin
				next_rdata[BIT_LOST_FLAG] = loop_one_lock_lost_flag;
				next_rdata[BIT_LOCK_LIVE] = loop_one_lock_live;
				next_rdata[BIT_LOST_CLEAR] = loop_one_lock_lost_clear;
			end
			OFS_LOOP_TWO_LOCK: begin
				next_rdata[BIT_LOST_FLAG] = loop_two_lock_lost_flag;
				next_rdata[BIT_LOCK_LIVE] = loop_two_lock_live;
				next_rdata[BIT_LOST_CLEAR] = loop_two_lock_lost_clear;
			end
			OFS_INPUT_SEL_LOS: begin
				next_rdata[DATA_W-1:BIT_DAC_HIGH] = holdover_dac_readback[DAC_W-1:DATA_W];
				next_rdata[BIT_SEL_C] = ref_selected[2];
				next_rdata[BIT_SEL_B] = ref_selected[1];
				next_rdata[BIT_SEL_A] = ref_selected[0];
				next_rdata[BIT_LOS_B] = ref_signal_loss[1];
				next_rdata[BIT_LOS_A] = ref_signal_loss[0];
			end
			OFS_DAC_LOW: next_rdata = holdover_dac_readback[DATA_W-1:0];
			OFS_HOLDOVER: next_rdata[BIT_HOLDOVER] = holdover_active;
			default: next_rdata = '0;
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			reg_rdata_out <= '0;
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rvalid_out <= reg_read_in;
			if (reg_read_in) begin
				reg_rdata_out <= next_rdata;
			end
		end
	end

	sequence read_of_s(logic [ADDR_W-1:0] ofs);
		reg_read_in && reg_addr_in == ofs;
	endsequence

	sequence power_write_s;
		wr_power;
	endsequence

	AST_PRESCALER_OFF: assert property (@(posedge clock_in) disable iff (reset_in)
		power_write_s |=> loop_two_prescaler_off_out == $past(reg_wdata_in[BIT_PRESCALER_OFF]))
		else $error("prescaler powerdown does not follow write");

	AST_LOOP_OFF: assert property (@(posedge clock_in) disable iff (reset_in)
		loop_two_off_out |=> !loop_two_lock_live_out)
		else $error("powered down loop two reports lock");

	AST_POWER_RESERVED: assert property (@(posedge clock_in) disable iff (reset_in)
		(loop_two_power & ~MASK_LOOP_TWO_POWER) == '0)
		else $error("reserved power bits stored");

	AST_LIVE_ONE: assert property (@(posedge clock_in) disable iff (reset_in)
		read_of_s(OFS_LOOP_ONE_LOCK) |=>
			reg_rvalid_out && reg_rdata_out[BIT_LOCK_LIVE] == $past(loop_one_lock_live))
		else $error("loop one live bit mismatch");

	AST_RESERVED_LOCK: assert property (@(posedge clock_in) disable iff (reset_in)
		read_of_s(OFS_LOOP_TWO_LOCK) |=> reg_rdata_out[DATA_W-1:3] == '0)
		else $error("reserved lock bits nonzero");

	AST_SEL_ONEHOT: assert property (@(posedge clock_in) disable iff (reset_in)
		ref_select_valid_in && ref_select_in == REF_C |=> ref_selected == 3'h4)
		else $error("reference selection bit wrong");

	AST_LOS_READ: assert property (@(posedge clock_in) disable iff (reset_in)
		ref_input_b_signal_loss_in ##1 read_of_s(OFS_INPUT_SEL_LOS) |=>
			reg_rdata_out[BIT_LOS_B])
		else $error("signal loss not shown");

	AST_DAC_HOLD: assert property (@(posedge clock_in) disable iff (reset_in)
		!loop_one_locked_once |-> holdover_dac_readback == RST_DAC_VALUE)
		else $error("DAC readback moved before lock");

	AST_DAC_SPLIT: assert property (@(posedge clock_in) disable iff (reset_in)
		read_of_s(OFS_DAC_LOW) |=> reg_rdata_out == $past(holdover_dac_readback[7:0]))
		else $error("DAC low byte mismatch");

	AST_HOLDOVER_READ: assert property (@(posedge clock_in) disable iff (reset_in)
		holdover_active_in ##1 read_of_s(OFS_HOLDOVER) |=>
			reg_rdata_out == 8'h10)
		else $error("holdover bit not shown");

	AST_VALID_GATE: assert property (@(posedge clock_in) disable iff (reset_in)
		status_pin_a_selector_in != SEL_LOOP_TWO_LOCK &&
		status_pin_b_selector_in != SEL_LOOP_TWO_LOCK |-> !loop_two_lock_valid_out)
		else $error("loop two valid without selector");
endmodule // pms_status_bank

//--- dv/pms_host_model.sv
// Host controller model that drives the bank's register port
`timescale 1ns/10ps
module pms_host_model (
	// Clock
	input wire logic clock_in,
	// Register port
	output logic [pms_pkg::ADDR_W-1:0] reg_addr_out,
	output logic reg_write_out,
	output logic reg_read_out,
	output logic [pms_pkg::DATA_W-1:0] reg_wdata_out
);
	import pms_pkg::*;
	initial begin
		reg_addr_out = '0;
		reg_write_out = 1'b0;
		reg_read_out = 1'b0;
		reg_wdata_out = '0;
	end
	// One-cycle strobes; the bank answers without a handshake
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clock_in);
		reg_addr_out <= a;
		reg_wdata_out <= d;
		reg_write_out <= 1'b1;
		@(posedge clock_in);
		reg_write_out <= 1'b0;
		reg_wdata_out <= ~d;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge clock_in);
		reg_addr_out <= a;
		reg_read_out <= 1'b1;
		@(posedge clock_in);
		reg_read_out <= 1'b0;
	endtask
	task automatic init_seq();
		wr(OFS_FIXED_VALUE_B, 8'h02);
		wr(OFS_OSC_TUNING_A, 8'h15);
		wr(OFS_OSC_TUNING_B, 8'h33);
		// Calibration start must come after both tuning writes; it lies outside this bank
		wr(13'h0168, 8'h01);
	endtask
	task automatic clear_flag(input logic [ADDR_W-1:0] a);
		wr(a, 8'h01);
		wr(a, 8'h00);
	endtask
endmodule // pms_host_model

//--- dv/pms_status_bank_bench.sv
// Self-checking bench for the loop status register bank
`timescale 1ns/10ps
module pms_status_bank_bench;
	import pms_pkg::*;
	localparam int L1 = 3;
	localparam int L2 = 2;
	typedef struct {string name; logic [DATA_W-1:0] val;} pms_note_t;
	logic clock_in = 1'b0;
	logic reset_in = 1'b1;
	logic [ADDR_W-1:0] reg_addr;
	logic reg_write, reg_read, rvalid, pre_off, l2_off, tun_ld, live1, live2, l2_valid;
	logic [DATA_W-1:0] reg_wdata, rdata, fixed_v, tun_a, tun_b, e;
	logic ev1 = 1'b0, win1 = 1'b0, ev2 = 1'b0, win2 = 1'b0, sel_valid = 1'b0;
	logic los_a = 1'b0, los_b = 1'b0, dac_upd = 1'b0, hold = 1'b0;
	logic [1:0] sel = 2'h3;
	logic [DAC_W-1:0] dac_val = '0, dac_exp;
	logic [SEL_W-1:0] pin_a = '0, pin_b = '0;
	logic [7:0] lf = 8'h56;
	logic [7:0] pwr [4] = '{8'hFF, 8'h40, 8'h20, 8'h00};
	int n_fail = 0;
	int checks = 0;
	pms_note_t exp_q[$];

	always #10 clock_in = ~clock_in;

	pms_host_model pms_host_model_i (.clock_in(clock_in), .reg_addr_out(reg_addr),
		.reg_write_out(reg_write), .reg_read_out(reg_read), .reg_wdata_out(reg_wdata));

	pms_status_bank #(.LOOP_ONE_LOCK_COUNT(L1), .LOOP_TWO_LOCK_COUNT(L2)) pms_status_bank_i (
		.clock_in(clock_in), .reset_in(reset_in),
		.reg_addr_in(reg_addr), .reg_write_in(reg_write), .reg_read_in(reg_read),
		.reg_wdata_in(reg_wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
		.loop_one_pd_event_in(ev1), .loop_one_in_window_in(win1),
		.loop_two_pd_event_in(ev2), .loop_two_in_window_in(win2),
		.ref_select_valid_in(sel_valid), .ref_select_in(sel),
		.ref_input_a_signal_loss_in(los_a), .ref_input_b_signal_loss_in(los_b),
		.dac_update_in(dac_upd), .dac_value_in(dac_val), .holdover_active_in(hold),
		.status_pin_a_selector_in(pin_a), .status_pin_b_selector_in(pin_b),
		.loop_two_prescaler_off_out(pre_off), .loop_two_off_out(l2_off),
		.fixed_value_b_out(fixed_v), .osc_tuning_a_out(tun_a), .osc_tuning_b_out(tun_b),
		.osc_tuning_loaded_out(tun_ld), .loop_one_lock_live_out(live1),
		.loop_two_lock_live_out(live2), .loop_two_lock_valid_out(l2_valid));

	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// The note goes in before the strobe so the answer always finds it
	task automatic expect_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		pms_note_t n;
		n.name = $sformatf("reg_%h", a);
		n.val = v;
		exp_q.push_back(n);
		pms_host_model_i.rd(a);
	endtask

	task automatic settle();
		repeat (4) @(posedge clock_in);
	endtask

	task automatic pd(input bit two, input logic w);
		@(posedge clock_in);
		if (two) begin
			ev2 <= 1'b1;
			win2 <= w;
		end else begin
			ev1 <= 1'b1;
			win1 <= w;
		end
		@(posedge clock_in);
		ev1 <= 1'b0;
		ev2 <= 1'b0;
	endtask

	task automatic lock(input bit two, input int n);
		repeat (n) pd(two, 1'b1);
	endtask

	task automatic dac_pulse(input logic [DAC_W-1:0] v);
		@(posedge clock_in);
		dac_upd <= 1'b1;
		dac_val <= v;
		@(posedge clock_in);
		dac_upd <= 1'b0;
		settle();
	endtask

	always @(posedge clock_in) begin
		if (rvalid === 1'b1) begin
			if (exp_q.size() == 0) begin
				n_fail++;
				$display("ERROR rdata expected none seen %h", rdata);
			end else begin
				check(exp_q[0].name, rdata, exp_q[0].val);
				void'(exp_q.pop_front());
			end
		end
	end

	initial begin
		repeat (20000) @(posedge clock_in);
		n_fail++;
		$display("ERROR watchdog expected end seen timeout");
		final_report();
	end

	initial begin
		repeat (3) @(posedge clock_in);
		reset_in <= 1'b0;
		// Loop one has never locked, so this update must not land
		dac_pulse(10'h3FF);
		expect_rd(OFS_FIXED_VALUE_B, 8'h00);
		expect_rd(OFS_LOOP_TWO_POWER, 8'h00);
		expect_rd(OFS_LOOP_ONE_LOCK, 8'h00);
		expect_rd(OFS_INPUT_SEL_LOS, 8'h80);
		expect_rd(OFS_DAC_LOW, 8'h00);
		expect_rd(13'h0180, 8'h00);
		check("tuning_loaded", {7'h00, tun_ld}, 8'h00);
		pms_host_model_i.init_seq();
		settle();
		check("fixed_value", fixed_v, 8'h02);
		check("tuning_a", tun_a, 8'h15);
		check("tuning_b", tun_b, 8'h33);
		check("tuning_loaded", {7'h00, tun_ld}, 8'h01);
		expect_rd(OFS_OSC_TUNING_B, 8'h33);
		foreach (pwr[i]) begin
			pms_host_model_i.wr(OFS_LOOP_TWO_POWER, pwr[i]);
			expect_rd(OFS_LOOP_TWO_POWER, pwr[i] & 8'h60);
			check("prescaler_off", {7'h00, pre_off}, {7'h00, pwr[i][6]});
			check("loop_two_off", {7'h00, l2_off}, {7'h00, pwr[i][5]});
		end
		// A miss mid-run restarts the count, so this run falls one short
		lock(0, 2);
		pd(0, 1'b0);
		lock(0, L1 - 1);
		settle();
		check("loop_one_live", {7'h00, live1}, 8'h00);
		lock(0, 1);
		settle();
		check("loop_one_live", {7'h00, live1}, 8'h01);
		expect_rd(OFS_LOOP_ONE_LOCK, 8'h02);
		pd(0, 1'b0);
		settle();
		expect_rd(OFS_LOOP_ONE_LOCK, 8'h04);
		pms_host_model_i.wr(OFS_LOOP_ONE_LOCK, 8'h01);
		expect_rd(OFS_LOOP_ONE_LOCK, 8'h01);
		pms_host_model_i.wr(OFS_LOOP_ONE_LOCK, 8'h00);
		settle();
		expect_rd(OFS_LOOP_ONE_LOCK, 8'h00);
		// A fall while clear is held is lost for good
		pms_host_model_i.wr(OFS_LOOP_ONE_LOCK, 8'h01);
		lock(0, L1);
		pd(0, 1'b0);
		settle();
		pms_host_model_i.wr(OFS_LOOP_ONE_LOCK, 8'h00);
		settle();
		expect_rd(OFS_LOOP_ONE_LOCK, 8'h00);
		lock(0, L1);
		pd(0, 1'b0);
		settle();
		expect_rd(OFS_LOOP_ONE_LOCK, 8'h04);
		pms_host_model_i.wr(OFS_LOOP_ONE_LOCK, 8'hFF);
		expect_rd(OFS_LOOP_ONE_LOCK, 8'h01);
		pms_host_model_i.wr(OFS_LOOP_ONE_LOCK, 8'h00);
		lf = lfsr_next(lf);
		dac_exp[9:8] = lf[1:0];
		lf = lfsr_next(lf);
		dac_exp[7:0] = lf;
		dac_pulse(dac_exp);
		expect_rd(OFS_INPUT_SEL_LOS, {dac_exp[9:8], 6'h00});
		expect_rd(OFS_DAC_LOW, dac_exp[7:0]);
		for (int i = 0; i < 3; i++) begin
			@(posedge clock_in);
			pin_a <= (i == 0) ? SEL_LOOP_TWO_LOCK : 5'h03;
			pin_b <= (i == 1) ? SEL_LOOP_TWO_LOCK : 5'h04;
			@(posedge clock_in);
			check("loop_two_valid", {7'h00, l2_valid}, {7'h00, i < 2});
		end
		pin_b <= SEL_LOOP_TWO_LOCK;
		lock(1, L2);
		settle();
		check("loop_two_live", {7'h00, live2}, 8'h01);
		expect_rd(OFS_LOOP_TWO_LOCK, 8'h02);
		pd(1, 1'b0);
		settle();
		expect_rd(OFS_LOOP_TWO_LOCK, 8'h04);
		pms_host_model_i.clear_flag(OFS_LOOP_TWO_LOCK);
		settle();
		expect_rd(OFS_LOOP_TWO_LOCK, 8'h00);
		for (int i = 0; i < 4; i++) begin
			lf = lfsr_next(lf);
			@(posedge clock_in);
			sel_valid <= 1'b1;
			sel <= i[1:0];
			los_a <= lf[0];
			los_b <= lf[1];
			settle();
			e = {dac_exp[9:8], i == 2, i == 1, i == 0, 1'b0, lf[1], lf[0]};
			expect_rd(OFS_INPUT_SEL_LOS, e);
		end
		for (int h = 1; h >= 0; h--) begin
			@(posedge clock_in);
			hold <= h[0];
			settle();
			expect_rd(OFS_HOLDOVER, {3'h0, h[0], 4'h0});
		end
		pms_host_model_i.wr(OFS_HOLDOVER, 8'hFF);
		expect_rd(OFS_HOLDOVER, 8'h00);
		settle();
		check("pending_reads", 8'(exp_q.size()), 8'h00);
		final_report();
	end
endmodule // pms_status_bank_bench
